/* File: dma_addr_defs.vh */
`ifndef DMA_ADDR_DEFS_VH
`define DMA_ADDR_DEFS_VH
// ****************************************
// I/O map
// ****************************************
`define IO_LOW_CMD 12'h008
`define IO_LOW_MODE 12'h00B
`define IO_LOW_CLRPTR 12'h00C
`define IO_HIGH_CMD 12'h0D0
`define IO_HIGH_MODE 12'h0D6
`define IO_HIGH_CLRPTR 12'h0D8
`define IO_PAGE_LO_BASE 12'h080
`define IO_PAGE_HI_BASE 12'h480
`define IO_SHADOW 12'h0B8
// ****************************************
// Fields and reset values
// ****************************************
`define CMD_ROTATE_BIT 4
`define MODE_TYPE_LSB 2
`define MODE_DEC_BIT 5
`define TYPE_VERIFY 2'h0
`define TYPE_WRITE 2'h1
`define TYPE_READ 2'h2
`define PAGE_RESET 8'h00
`define SHADOW_LAST 6'h3F
`endif

/* File: dma_fifo.v */
`timescale 1ns/1ns
// ****************************************
// Data buffer between memory and peripheral
// ****************************************
module dma_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire resetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // Flip-flop storage
    reg [AW:0] wr_reg; // Write pointer with wrap bit
    reg [AW:0] rd_reg; // Read pointer with wrap bit
    wire [AW:0] fill = wr_reg - rd_reg;
    // Widen the fill count rather than slicing the depth parameter
    assign in_ready = ({{(31-AW){1'b0}}, fill} != DEPTH);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_reg[AW-1:0]];
    // Pointers move only on accepted handshakes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
    // Storage has no reset; empty flag guards stale words
    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule // dma_fifo

/* File: dma_addr_ctrl.v */
`timescale 1ns/1ns
`include "dma_addr_defs.vh"
module dma_addr_ctrl #(
    parameter DW = 16,
    parameter FIFO_DEPTH = 16
) (
    input wire clk,
    input wire resetn,
    input wire io_wr,
    input wire io_rd,
    input wire [11:0] io_addr,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    input wire [7:0] dma_request_line,
    output reg [7:0] dma_acknowledge_line,
    output reg [31:0] mem_addr,
    output reg mem_rd_cmd,
    output reg mem_wr_cmd,
    output reg byte_high_enable_out,
    output reg bus_hold,
    input wire mem_done,
    input wire [DW-1:0] mem_rdata,
    output reg [DW-1:0] mem_wdata,
    input wire [DW-1:0] per_rdata,
    output reg [DW-1:0] per_wdata,
    output reg per_wr_strobe,
    output reg tc_pulse
);
    // ****************************************
    // Channel state
    // ****************************************
    reg [15:0] base_addr_reg [0:7]; // Read back only through the shadow port
    reg [15:0] cur_addr_reg [0:7];
    reg [15:0] base_cnt_reg [0:7]; // Read back only through the shadow port
    reg [15:0] cur_cnt_reg [0:7];
    reg [7:0] page_lo_reg [0:15]; // 080h..08Fh storage
    reg [7:0] page_hi_reg [0:15]; // 480h..48Fh storage
    reg [5:0] mode_reg [0:7]; // Type and direction per channel
    reg [1:0] cmd_reg; // Rotate bit per controller
    reg ptr_reg; // Byte pointer, 0 = low
    reg [5:0] shadow_reg; // Shadow sequence index
    reg [2:0] last_reg [0:1]; // Last serviced per controller
    reg [2:0] chan_reg; // Active channel
    reg [2:0] state_reg;
    reg [7:0] seen_reg; // Requests already served this assertion
    integer i;
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_XFER = 3'b010;
    localparam [2:0] S_DONE = 3'b100;
    // ****************************************
    // Helpers
    // ****************************************
    // Page register index for each channel, AT layout
    function [3:0] page_idx;
        input [2:0] ch;
        begin
            case (ch)
                3'd0: page_idx = 4'h7;
                3'd1: page_idx = 4'h3;
                3'd2: page_idx = 4'h1;
                3'd3: page_idx = 4'h2;
                3'd5: page_idx = 4'hB;
                3'd6: page_idx = 4'h9;
                3'd7: page_idx = 4'hA;
                default: page_idx = 4'hF;
            endcase
        end
    endfunction
    // Page index back to channel, 8 when spare storage
    function [3:0] page_chan;
        input [3:0] idx;
        begin
            case (idx)
                4'h7: page_chan = 4'd0;
                4'h3: page_chan = 4'd1;
                4'h1: page_chan = 4'd2;
                4'h2: page_chan = 4'd3;
                4'hB: page_chan = 4'd5;
                4'h9: page_chan = 4'd6;
                4'hA: page_chan = 4'd7;
                default: page_chan = 4'd8;
            endcase
        end
    endfunction
    // Pick a winner among four requests with a given last grant
    function [1:0] pick4;
        input [3:0] req;
        input rot;
        input [1:0] last;
        reg [1:0] k;
        reg [1:0] c;
        reg found;
        integer j;
        begin
            pick4 = 2'd0;
            found = 1'b0;
            for (j = 0; j < 4; j = j + 1) begin
                k = j[1:0];
                c = rot ? (last + 2'd1 + k) : k;
                if (!found && req[c]) begin
                    pick4 = c;
                    found = 1'b1;
                end
            end
        end
    endfunction
    // Channel group decode: address register slot in a controller
    wire low_grp = (io_addr[11:4] == 8'h00);
    wire high_grp = (io_addr[11:5] == 7'h06);
    wire [2:0] reg_ch = low_grp ? {1'b0, io_addr[2:1]} : {1'b1, io_addr[3:2]};
    wire is_cnt = low_grp ? io_addr[0] : io_addr[1];
    wire ch_access = (low_grp && !io_addr[3]) ||
                     (high_grp && !io_addr[4] && !io_addr[0] && io_addr[3:2] != 2'b00);
    wire page_lo_hit = (io_addr[11:4] == 8'h08);
    wire page_hi_hit = (io_addr[11:4] == 8'h48);
    wire [3:0] pch = page_chan(io_addr[3:0]);
    // ****************************************
    // Arbitration
    // ****************************************
    wire [7:0] live = dma_request_line & ~seen_reg & 8'hEF;
    wire low_any = |live[3:0];
    wire [1:0] low_win = pick4(live[3:0], cmd_reg[0], last_reg[0][1:0]);
    wire [1:0] high_win = pick4(live[7:4], cmd_reg[1], last_reg[1][1:0]);
    // Low controller cascades through master channel 4's slot
    wire [3:0] master_req = {live[7:5], low_any};
    wire [1:0] m_win = pick4(master_req, cmd_reg[1], last_reg[1][1:0]);
    wire [2:0] grant = (m_win == 2'd0) ? {1'b0, low_win} : {1'b1, m_win};
    wire wide = chan_reg[2];
    wire [5:0] cur_mode = mode_reg[chan_reg];
    wire [1:0] ttype = cur_mode[`MODE_TYPE_LSB+1:`MODE_TYPE_LSB];
    wire [15:0] ca = cur_addr_reg[chan_reg];
    wire [3:0] pi = page_idx(chan_reg);
    // ****************************************
    // FIFO between peripheral and memory
    // ****************************************
    wire f_in_ready;
    wire f_out_valid;
    wire [DW-1:0] f_out_data;
    reg f_in_valid;
    reg f_out_ready;
    reg [DW-1:0] f_in_data;
    dma_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );
    // FIFO steering from the transfer state
    always @* begin
        f_in_valid = 1'b0;
        f_in_data = mem_rdata;
        f_out_ready = 1'b0;
        if (state_reg == S_XFER && mem_done) begin
            f_in_valid = 1'b1;
            f_in_data = (ttype == `TYPE_READ) ? mem_rdata : per_rdata;
        end
        if (state_reg == S_DONE) begin
            f_out_ready = 1'b1;
        end
    end
    // ****************************************
    // Register file, arbitration and transfer engine
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                base_addr_reg[i] <= 16'h0000;
                cur_addr_reg[i] <= 16'h0000;
                base_cnt_reg[i] <= 16'h0000;
                cur_cnt_reg[i] <= 16'h0000;
                mode_reg[i] <= 6'h00;
            end
            for (i = 0; i < 16; i = i + 1) begin
                page_lo_reg[i] <= `PAGE_RESET;
                page_hi_reg[i] <= `PAGE_RESET;
            end
            cmd_reg <= 2'b00;
            ptr_reg <= 1'b0;
            shadow_reg <= 6'h00;
            last_reg[0] <= 3'd3;
            last_reg[1] <= 3'd3;
            chan_reg <= 3'd0;
            state_reg <= S_IDLE;
            seen_reg <= 8'h00;
            io_rdata <= 8'h00;
            dma_acknowledge_line <= 8'hFF;
            mem_addr <= 32'h0000_0000;
            mem_rd_cmd <= 1'b0;
            mem_wr_cmd <= 1'b0;
            byte_high_enable_out <= 1'b1;
            bus_hold <= 1'b0;
            mem_wdata <= {DW{1'b0}};
            per_wdata <= {DW{1'b0}};
            per_wr_strobe <= 1'b0;
            tc_pulse <= 1'b0;
        end else begin
            per_wr_strobe <= 1'b0;
            tc_pulse <= 1'b0;
            // A request is served once until it drops
            seen_reg <= seen_reg & dma_request_line;
            // Software writes
            if (io_wr) begin
                if (ch_access) begin
                    if (is_cnt) begin
                        if (ptr_reg) begin
                            base_cnt_reg[reg_ch][15:8] <= io_wdata;
                            cur_cnt_reg[reg_ch][15:8] <= io_wdata;
                        end else begin
                            base_cnt_reg[reg_ch][7:0] <= io_wdata;
                            cur_cnt_reg[reg_ch][7:0] <= io_wdata;
                        end
                    end else begin
                        if (ptr_reg) begin
                            base_addr_reg[reg_ch][15:8] <= io_wdata;
                            cur_addr_reg[reg_ch][15:8] <= io_wdata;
                        end else begin
                            base_addr_reg[reg_ch][7:0] <= io_wdata;
                            cur_addr_reg[reg_ch][7:0] <= io_wdata;
                        end
                    end
                    ptr_reg <= ~ptr_reg;
                end else if (io_addr == `IO_LOW_CMD) begin
                    cmd_reg[0] <= io_wdata[`CMD_ROTATE_BIT];
                end else if (io_addr == `IO_HIGH_CMD) begin
                    cmd_reg[1] <= io_wdata[`CMD_ROTATE_BIT];
                end else if (io_addr == `IO_LOW_MODE) begin
                    mode_reg[{1'b0, io_wdata[1:0]}] <= io_wdata[5:0];
                end else if (io_addr == `IO_HIGH_MODE) begin
                    mode_reg[{1'b1, io_wdata[1:0]}] <= io_wdata[5:0];
                end else if (io_addr == `IO_LOW_CLRPTR || io_addr == `IO_HIGH_CLRPTR) begin
                    ptr_reg <= 1'b0;
                end else if (io_addr == `IO_SHADOW) begin
                    shadow_reg <= 6'h00; // Restart readback sequence
                end else if (page_lo_hit) begin
                    page_lo_reg[io_addr[3:0]] <= io_wdata;
                    if (pch != 4'd8) begin
                        page_hi_reg[io_addr[3:0]] <= 8'h00;
                    end
                end else if (page_hi_hit) begin
                    page_hi_reg[io_addr[3:0]] <= io_wdata;
                end
            end
            // Software reads, current copies at channel ports, base copies at shadow
            if (io_rd) begin
                io_rdata <= 8'h00;
                if (ch_access) begin
                    if (is_cnt) begin
                        io_rdata <= ptr_reg ? cur_cnt_reg[reg_ch][15:8] : cur_cnt_reg[reg_ch][7:0];
                    end else begin
                        io_rdata <= ptr_reg ? cur_addr_reg[reg_ch][15:8] : cur_addr_reg[reg_ch][7:0];
                    end
                    ptr_reg <= ~ptr_reg;
                end else if (page_lo_hit) begin
                    io_rdata <= page_lo_reg[io_addr[3:0]];
                end else if (page_hi_hit) begin
                    io_rdata <= page_hi_reg[io_addr[3:0]];
                end else if (io_addr == `IO_SHADOW) begin
                    // Base copies, then mode bytes and command bits
                    if (shadow_reg[5]) begin
                        io_rdata <= shadow_reg[4] ? {6'h00, cmd_reg} : {2'b00, mode_reg[shadow_reg[2:0]]};
                    end else begin
                        io_rdata <= shadow_reg[4] ?
                            (shadow_reg[0] ? base_cnt_reg[shadow_reg[3:1]][15:8] :
                                             base_cnt_reg[shadow_reg[3:1]][7:0]) :
                            (shadow_reg[0] ? base_addr_reg[shadow_reg[3:1]][15:8] :
                                             base_addr_reg[shadow_reg[3:1]][7:0]);
                    end
                    // A restart write in the same cycle wins over the step
                    shadow_reg <= (io_wr || shadow_reg == `SHADOW_LAST) ? 6'h00 :
                                  shadow_reg + 6'h01;
                end
            end
            // Transfer engine
            case (state_reg)
                S_IDLE: begin
                    dma_acknowledge_line <= 8'hFF;
                    bus_hold <= 1'b0;
                    if (|live) begin
                        chan_reg <= grant;
                        state_reg <= S_XFER;
                    end
                end
                S_XFER: begin
                    bus_hold <= 1'b1;
                    dma_acknowledge_line <= ~(8'h01 << chan_reg);
                    // Write data stands with the command, not after it
                    mem_wdata <= per_rdata;
                    // Page never receives a carry from the address counter
                    if (wide) begin
                        mem_addr <= {page_hi_reg[pi], page_lo_reg[pi][7:1], ca, 1'b0};
                        byte_high_enable_out <= 1'b0;
                    end else begin
                        mem_addr <= {page_hi_reg[pi], page_lo_reg[pi], ca};
                        byte_high_enable_out <= ~ca[0];
                    end
                    mem_rd_cmd <= (ttype == `TYPE_READ) && f_in_ready;
                    mem_wr_cmd <= (ttype == `TYPE_WRITE) && f_in_ready;
                    if (ttype == `TYPE_VERIFY || ttype == 2'h3 || (mem_done && f_in_ready)) begin
                        mem_rd_cmd <= 1'b0;
                        mem_wr_cmd <= 1'b0;
                        if (cur_mode[`MODE_DEC_BIT]) begin
                            cur_addr_reg[chan_reg] <= ca - 16'h0001;
                        end else begin
                            cur_addr_reg[chan_reg] <= ca + 16'h0001;
                        end
                        cur_cnt_reg[chan_reg] <= cur_cnt_reg[chan_reg] - 16'h0001;
                        tc_pulse <= (cur_cnt_reg[chan_reg] == 16'h0000);
                        seen_reg[chan_reg] <= 1'b1;
                        if (chan_reg[2]) begin
                            last_reg[1] <= {1'b0, chan_reg[1:0]};
                        end else begin
                            last_reg[0] <= {1'b0, chan_reg[1:0]};
                            last_reg[1] <= 3'd0;
                        end
                        state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    // Release bus after every single cycle
                    bus_hold <= 1'b0;
                    dma_acknowledge_line <= 8'hFF;
                    if (f_out_valid && ttype == `TYPE_READ) begin
                        per_wdata <= f_out_data;
                        per_wr_strobe <= 1'b1;
                    end
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // dma_addr_ctrl

/* File: dma_far_side.sv */
`timescale 1ns/1ns
// ****
// Far side: requesting peripherals and memory
// ****
module dma_far_side (
    input wire clk,
    input wire resetn,
    input wire [7:0] arm,
    input wire [3:0] mem_wait,
    input wire [7:0] dma_acknowledge_line,
    input wire mem_rd_cmd,
    input wire mem_wr_cmd,
    input wire [31:0] mem_addr,
    output reg [7:0] dma_request_line,
    output reg mem_done,
    output wire [15:0] mem_rdata
);
    reg [3:0] wait_reg; // Cycles spent on this access
    wire busy = (mem_rd_cmd || mem_wr_cmd) && !mem_done; // Access still open
    wire [15:0] pattern = mem_addr[15:0] ^ 16'h5A5A; // Data tied to address
    // Outside a read the bus shows the inverse, so a late sample cannot pass
    assign mem_rdata = mem_rd_cmd ? pattern : ~pattern;
    // Request rises on arm and holds, active high, until acknowledge goes low
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dma_request_line <= 8'h00;
        end else begin
            dma_request_line <= (dma_request_line | arm) & dma_acknowledge_line;
        end
    end
    // Memory finishes after mem_wait cycles, one done pulse per command
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= 4'h0;
            mem_done <= 1'b0;
        end else if (busy && wait_reg >= mem_wait) begin
            wait_reg <= 4'h0;
            mem_done <= 1'b1;
        end else begin
            wait_reg <= busy ? wait_reg + 4'h1 : 4'h0;
            mem_done <= 1'b0;
        end
    end
endmodule // dma_far_side

/* File: dma_addr_ctrl_properties.sv */
`timescale 1ns/1ns
// ****
// Port checks of the address controller
// ****
module dma_addr_ctrl_properties (
    input wire clk,
    input wire resetn,
    input wire [7:0] dma_acknowledge_line,
    input wire [31:0] mem_addr,
    input wire mem_rd_cmd,
    input wire mem_wr_cmd,
    input wire byte_high_enable_out,
    input wire bus_hold,
    input wire mem_done,
    input wire per_wr_strobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire any_cmd = mem_rd_cmd || mem_wr_cmd; // Either memory strobe
    wire narrow = ~&dma_acknowledge_line[3:0]; // Byte channel granted
    wire wide = ~&dma_acknowledge_line[7:5]; // Word channel granted
    // Read step: memory answers, then the item goes out
    sequence s_read_finish;
        mem_rd_cmd && mem_done;
    endsequence
    sequence s_deliver;
        ##[1:3] per_wr_strobe;
    endsequence
    property p_one_grant;
        $onehot0(~dma_acknowledge_line);
    endproperty
    property p_grant_holds_bus;
        narrow || wide |-> bus_hold;
    endproperty
    property p_cmd_waits;
        any_cmd && !mem_done |=> any_cmd;
    endproperty
    property p_cmd_ends;
        any_cmd && mem_done |=> !any_cmd;
    endproperty
    property p_addr_stands;
        any_cmd && $past(any_cmd) |-> $stable(mem_addr);
    endproperty
    property p_bhe_narrow;
        any_cmd && narrow |-> byte_high_enable_out == !mem_addr[0];
    endproperty
    property p_bhe_wide;
        any_cmd && wide |-> !byte_high_enable_out && !mem_addr[0];
    endproperty
    property p_read_delivers;
        s_read_finish |-> s_deliver;
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("two channels granted");
    a_grant_holds_bus: assert property (p_grant_holds_bus)
        else $error("grant without bus hold");
    a_cmd_waits: assert property (p_cmd_waits)
        else $error("command dropped before done");
    a_cmd_ends: assert property (p_cmd_ends)
        else $error("command kept after done");
    a_addr_stands: assert property (p_addr_stands)
        else $error("address moved during command");
    a_bhe_narrow: assert property (p_bhe_narrow)
        else $error("byte high enable wrong on byte cycle");
    a_bhe_wide: assert property (p_bhe_wide)
        else $error("word cycle enable or bit 0 wrong");
    a_read_delivers: assert property (p_read_delivers)
        else $error("read item not delivered");
endmodule // dma_addr_ctrl_properties
bind dma_addr_ctrl dma_addr_ctrl_properties chk (.clk(clk), .resetn(resetn),
    .dma_acknowledge_line(dma_acknowledge_line), .mem_addr(mem_addr),
    .mem_rd_cmd(mem_rd_cmd), .mem_wr_cmd(mem_wr_cmd), .bus_hold(bus_hold),
    .byte_high_enable_out(byte_high_enable_out), .mem_done(mem_done),
    .per_wr_strobe(per_wr_strobe));

/* File: dma_addr_ctrl_bench.sv */
`timescale 1ns/1ns
module dma_addr_ctrl_bench;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg io_wr = 1'b0;
    reg io_rd = 1'b0;
    reg [11:0] io_addr = 12'h000;
    reg [7:0] io_wdata = 8'h00;
    reg [15:0] per_rdata = 16'hBEEF; // Peripheral word for write type
    reg [7:0] arm = 8'h00; // One-cycle request launch
    reg [3:0] mem_wait = 4'h1; // Memory latency, varied per transfer
    wire [7:0] io_rdata, req, ack;
    wire [31:0] mem_addr;
    wire rd_cmd, wr_cmd, bhe, hold, done, pw_stb, tc;
    wire [15:0] mem_rdata, mem_wdata, per_wdata;
    integer num_errors = 0;
    integer total_checks = 0;
    integer cycles = 0;
    reg [7:0] rd8; // Last byte read back
    reg [15:0] pw; // Last item handed to the peripheral
    reg saw_rd, saw_wr, saw_tc; // Strobes and terminal count seen in a transfer
    reg [7:0] first; // First grant seen, active high
    always #25 clk = ~clk;
    dma_addr_ctrl dut (.clk(clk), .resetn(resetn), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .dma_request_line(req), .dma_acknowledge_line(ack), .mem_addr(mem_addr),
        .mem_rd_cmd(rd_cmd), .mem_wr_cmd(wr_cmd), .byte_high_enable_out(bhe),
        .bus_hold(hold), .mem_done(done), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
        .per_rdata(per_rdata), .per_wdata(per_wdata), .per_wr_strobe(pw_stb), .tc_pulse(tc));
    dma_far_side far (.clk(clk), .resetn(resetn), .arm(arm), .mem_wait(mem_wait),
        .dma_acknowledge_line(ack), .mem_rd_cmd(rd_cmd), .mem_wr_cmd(wr_cmd),
        .mem_addr(mem_addr), .dma_request_line(req), .mem_done(done), .mem_rdata(mem_rdata));
    // ****
    // Shared tasks
    // ****
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk);
            io_addr <= a;
            io_wdata <= d;
            io_wr <= 1'b1;
            @(posedge clk);
            io_wr <= 1'b0;
        end
    endtask
    // Data lands the cycle after the strobe, sampled once settled
    task rdc(input [11:0] a, input [7:0] e);
        begin
            @(posedge clk);
            io_addr <= a;
            io_rd <= 1'b1;
            @(posedge clk);
            io_rd <= 1'b0;
            #1;
            rd8 = io_rdata;
            chk("io_rdata", {24'h0, e}, {24'h0, rd8});
        end
    endtask
    // Launch requests on mask, follow until all idle for three cycles
    task xfer(input [7:0] mask, input [3:0] w);
        integer n, after;
        begin
            saw_rd = 1'b0;
            saw_wr = 1'b0;
            saw_tc = 1'b0;
            first = 8'h00;
            after = 0;
            @(posedge clk);
            arm <= mask;
            mem_wait <= w;
            @(posedge clk);
            arm <= 8'h00;
            for (n = 0; n < 80 && after < 3; n = n + 1) begin
                @(posedge clk);
                #1;
                if (first === 8'h00) first = ~ack;
                saw_rd = saw_rd | rd_cmd;
                saw_wr = saw_wr | wr_cmd;
                saw_tc = saw_tc | tc;
                if (pw_stb === 1'b1) pw = per_wdata;
                after = (req === 8'h00 && ack === 8'hFF && hold === 1'b0) ? after + 1 : 0;
            end
            chk("transfer_end", 32'h3, after);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_regs;
        begin
            wr(12'h00C, 8'h00);
            wr(12'h002, 8'h34);
            wr(12'h002, 8'h12);
            rdc(12'h002, 8'h34);
            rdc(12'h002, 8'h12);
            wr(12'h002, 8'h56);
            wr(12'h00C, 8'h00);
            rdc(12'h002, 8'h56);
            rdc(12'h002, 8'h12);
            rdc(12'h3FF, 8'h00);
        end
    endtask
    task t_page;
        begin
            rdc(12'h083, 8'h00);
            rdc(12'h48F, 8'h00);
            wr(12'h08F, 8'hA5);
            rdc(12'h08F, 8'hA5);
            wr(12'h483, 8'h77);
            wr(12'h083, 8'h56);
            rdc(12'h483, 8'h00);
            wr(12'h483, 8'h9A);
        end
    endtask
    // Byte channel read type crossing the top of its page, fast then slow memory
    task t_read;
        begin
            wr(12'h002, 8'hFF);
            wr(12'h002, 8'hFF);
            wr(12'h003, 8'h01);
            wr(12'h003, 8'h00);
            wr(12'h00B, 8'h09);
            xfer(8'h02, 4'h1);
            chk("mem_addr", 32'h9A56FFFF, mem_addr);
            chk("read_strobes", 32'h2, {saw_rd, saw_wr});
            chk("per_wdata", 32'hA5, pw[7:0]);
            chk("tc_pulse", 32'h0, saw_tc);
            xfer(8'h02, 4'h6);
            chk("mem_addr", 32'h9A560000, mem_addr);
            chk("per_wdata", 32'h5A, pw[7:0]);
            wr(12'h00C, 8'h00);
            rdc(12'h002, 8'h01);
            rdc(12'h002, 8'h00);
            rdc(12'h003, 8'hFF);
            rdc(12'h003, 8'hFF);
        end
    endtask
    // Verify type on two channels, fixed then rotating ranking
    task t_prio;
        begin
            wr(12'h00B, 8'h02);
            wr(12'h00B, 8'h03);
            xfer(8'h04, 4'h1);
            xfer(8'h0C, 4'h1);
            chk("first_grant", 32'h04, first);
            chk("verify_strobes", 32'h0, {saw_rd, saw_wr});
            wr(12'h008, 8'h10);
            xfer(8'h04, 4'h1);
            xfer(8'h0C, 4'h1);
            chk("first_grant", 32'h08, first);
            wr(12'h008, 8'h00);
        end
    endtask
    // Word channel write type, address and count in word units
    task t_wide;
        begin
            wr(12'h0D8, 8'h00);
            wr(12'h0C4, 8'h00);
            wr(12'h0C4, 8'h20);
            wr(12'h0C6, 8'h00);
            wr(12'h0C6, 8'h00);
            wr(12'h48B, 8'h55);
            wr(12'h08B, 8'h02);
            rdc(12'h48B, 8'h00);
            wr(12'h0D6, 8'h25);
            xfer(8'h20, 4'h2);
            chk("mem_addr", 32'h00024000, mem_addr);
            chk("write_strobes", 32'h1, {saw_rd, saw_wr});
            chk("mem_wdata", 32'hBEEF, mem_wdata);
            chk("tc_pulse", 32'h1, saw_tc);
            wr(12'h0D8, 8'h00);
            rdc(12'h0C4, 8'hFF);
            rdc(12'h0C4, 8'h1F);
        end
    endtask
    // Base copy of the byte channel stays put while its current copy moved
    task t_shadow;
        begin
            wr(12'h0B8, 8'h00);
            rdc(12'h0B8, 8'h00);
            rdc(12'h0B8, 8'h00);
            rdc(12'h0B8, 8'hFF);
            rdc(12'h0B8, 8'hFF);
        end
    endtask
    task results;
        begin
            if (num_errors == 0 && total_checks > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // Hang guard, far beyond the fewer than two hundred cycles the run needs
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            results;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("reset_outputs", 32'h3FE, {22'h0, ack, bhe, hold});
        t_regs;
        t_page;
        t_read;
        t_prio;
        t_wide;
        t_shadow;
        results;
    end
endmodule // dma_addr_ctrl_bench
